// >>> hdl/usc_pkg.sv
// Package for the serial transceiver clock generator and frame format.
// Assumes one system clock mclk at 25 MHz shared by both ends.
package usc_pkg;
	localparam int DIV_W = 12;
	localparam logic [11:0] DIV_RESET = 12'h000;
	localparam logic [4:0] OVS_NORMAL = 5'h10;
	localparam logic [4:0] OVS_DOUBLE = 5'h08;
	localparam logic [4:0] OVS_SYNC = 5'h02;
	localparam logic [3:0] MID_NORMAL = 4'h7;
	localparam logic [3:0] MID_DOUBLE = 4'h3;
	localparam logic [2:0] SIZE_5 = 3'h0;
	localparam logic [2:0] SIZE_9 = 3'h7;
	localparam logic [1:0] PAR_NONE = 2'h0;
	localparam logic [1:0] PAR_EVEN = 2'h2;
	localparam logic [1:0] PAR_ODD = 2'h3;
	localparam int FIFO_DEPTH = 2;
	localparam logic [3:0] ADDR_DATA = 4'h0;
	localparam logic [3:0] ADDR_STAT = 4'h1;
	localparam logic [3:0] ADDR_DIVL = 4'h2;
	localparam logic [3:0] ADDR_DIVH = 4'h3;
	localparam logic [3:0] ADDR_CTRL = 4'h4;
	localparam logic [3:0] ADDR_HDATA = 4'h8;
	localparam logic [3:0] ADDR_HSTAT = 4'h9;
	localparam logic [3:0] ADDR_HCTRL = 4'hA;

	typedef enum logic [2:0] {
		USC_IDLE = 3'b000,
		USC_START = 3'b001,
		USC_DATA = 3'b011,
		USC_PAR = 3'b010,
		USC_STOP1 = 3'b110,
		USC_STOP2 = 3'b111
	} usc_state_e;

	// Number of data bits for a size code; codes 4..6 fall back to 8
	function automatic logic [3:0] usc_nbits(input logic [2:0] sz);
		if (sz == SIZE_9) begin
			return 4'h9;
		end else if (sz > 3'h3) begin
			return 4'h8;
		end
		return 4'h5 + {1'b0, sz};
	endfunction : usc_nbits

	function automatic logic usc_parity(input logic [8:0] d,
		input logic [3:0] n, input logic odd);
		logic p;
		p = odd;
		for (int i = 0; i < 9; i++) begin
			if (i < int'(n)) begin
				p = p ^ d[i];
			end
		end
		return p;
	endfunction : usc_parity
endpackage : usc_pkg

// >>> hdl/usc_link_if.sv
// Interface joining the two serial ends: data lines and transfer clock.
// Assumes the testbench resolves the clock pin from the two enables.
`timescale 1ns/100ps
`default_nettype none
interface usc_link_if;
	logic devTxd;
	logic peerTxd;
	logic devClkOut;
	logic devClkOe;
	logic peerClkOut;
	logic peerClkOe;
	logic clkPin;
	modport dev (output devTxd, input peerTxd, output devClkOut,
		output devClkOe, input clkPin);
	modport peer (output peerTxd, input devTxd, output peerClkOut,
		output peerClkOe, input clkPin);
endinterface : usc_link_if
`default_nettype wire

// >>> hdl/usc_dev.sv
// Device end: baud generator, clock modes, transmitter, receiver, 2-deep
// receive buffer. Assumes software on a plain strobe port, one clock.
//
// Our own choices: the register addresses and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - Two-entry receive FIFO, one read per character
// - Status stored per character, read status first
// - Shift register holds third character until start
// - Four clock modes from mode, direction and double-speed bits
// - Clock pin used only in synchronous mode
// - Counter reloads at zero or low write
// - Tick each zero, rate clock over divisor+1
// - Transmit divides by 16, 8 or 2
// - Receiver steps 16, 8 or 2 states
// - Divisor is twelve bits, 0 to 4095
// - Speed double ignored in synchronous mode
// - Double speed uses 8 samples per bit
// - External clock synchronised then edge detected
// - External clock below quarter system clock
// - Sample on edge opposite to change edge
// - Polarity picks change and sample edges
// - All 30 frame formats supported
// - Start, data LSB first, parity, stop
// - Stop bits high, idle high, back to back only with two stop bits
// - One format shared by both directions
// - Only first stop bit checked for error
// - Parity is data xor, inverted for odd
module usc_dev (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic [3:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [7:0] regRdata,
	usc_link_if.dev link
);
	// Control state
	logic [11:0] div_reg;
	logic [11:0] cnt_reg;
	logic syncMode_reg, clkDir_reg, dbl_reg, pol_reg, stop2_reg;
	logic [2:0] size_reg;
	logic [1:0] par_reg;
	logic txNinth_reg;
	logic [7:0] regRdata_reg;

	wire wrData = regWr && regAddr == usc_pkg::ADDR_DATA;
	wire wrDivL = regWr && regAddr == usc_pkg::ADDR_DIVL;
	wire wrDivH = regWr && regAddr == usc_pkg::ADDR_DIVH;
	wire wrCtrl = regWr && regAddr == usc_pkg::ADDR_CTRL;
	wire rdData = regRd && regAddr == usc_pkg::ADDR_DATA;
	wire [3:0] nBits = usc_pkg::usc_nbits(size_reg);
	wire slave = syncMode_reg && !clkDir_reg;
	wire master = syncMode_reg && clkDir_reg;

	// Baud generator
	wire baudTick = (cnt_reg == 12'h000);
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_reg <= usc_pkg::DIV_RESET;
		end else if (wrDivL || baudTick) begin
			cnt_reg <= wrDivL ? {div_reg[11:8], regWdata} : div_reg;
		end else begin
			cnt_reg <= cnt_reg - 12'h001;
		end
	end

	// Master clock output: toggles each tick, so period is two ticks
	logic xck_reg;
	logic [1:0] ckSync_reg;
	logic ckPrev_reg;
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			xck_reg <= 1'b0;
			ckSync_reg <= 2'b00;
			ckPrev_reg <= 1'b0;
		end else begin
			if (master && baudTick) begin
				xck_reg <= ~xck_reg;
			end
			ckSync_reg <= {ckSync_reg[0], link.clkPin};
			ckPrev_reg <= ckSync_reg[1];
		end
	end
	// Slave edges come from the second synchroniser stage only
	wire extRise = ckSync_reg[1] && !ckPrev_reg;
	wire extFall = !ckSync_reg[1] && ckPrev_reg;
	wire mRise = master && baudTick && (xck_reg == pol_reg);
	wire mFall = master && baudTick && (xck_reg != pol_reg);
	wire rise = slave ? extRise : mRise;
	wire fall = slave ? extFall : mFall;
	wire chgEdge = pol_reg ? fall : rise;
	wire smpEdge = pol_reg ? rise : fall;
	assign link.devClkOut = xck_reg ^ pol_reg;
	assign link.devClkOe = master;

	// Async step size: 16 or 8 ticks per bit
	wire [4:0] ovs = dbl_reg ? usc_pkg::OVS_DOUBLE : usc_pkg::OVS_NORMAL;

	// Transmitter
	usc_pkg::usc_state_e txSt_reg;
	logic [8:0] txSh_reg;
	logic [3:0] txCnt_reg, txBit_reg;
	logic txd_reg, txFull_reg;
	logic [8:0] txBuf_reg;
	wire txStep = syncMode_reg ? chgEdge
		: (baudTick && {1'b0, txCnt_reg} == ovs - 5'h01);
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			txSt_reg <= usc_pkg::USC_IDLE;
			txSh_reg <= 9'h000;
			txCnt_reg <= 4'h0;
			txBit_reg <= 4'h0;
			txd_reg <= 1'b1;
			txFull_reg <= 1'b0;
			txBuf_reg <= 9'h000;
		end else begin
			if (wrData) begin
				txBuf_reg <= {txNinth_reg, regWdata};
				txFull_reg <= 1'b1;
			end
			if (!syncMode_reg && baudTick) begin
				txCnt_reg <= txStep ? 4'h0 : txCnt_reg + 4'h1;
			end
			if (txStep) begin
				unique case (txSt_reg)
				usc_pkg::USC_IDLE, usc_pkg::USC_STOP2: begin
					if (txFull_reg && !wrData) begin
						txd_reg <= 1'b0;
						txSh_reg <= txBuf_reg;
						txFull_reg <= 1'b0;
						txSt_reg <= usc_pkg::USC_START;
					end else begin
						txd_reg <= 1'b1;
						txSt_reg <= usc_pkg::USC_IDLE;
					end
				end
				usc_pkg::USC_START, usc_pkg::USC_DATA: begin
					if (txSt_reg == usc_pkg::USC_START) begin
						txBit_reg <= 4'h0;
						txd_reg <= txSh_reg[0];
						txSt_reg <= usc_pkg::USC_DATA;
					end else if (txBit_reg + 4'h1 < nBits) begin
						txBit_reg <= txBit_reg + 4'h1;
						txd_reg <= txSh_reg[txBit_reg + 4'h1];
					end else if (par_reg[1]) begin
						txd_reg <= usc_pkg::usc_parity(txSh_reg, nBits,
							par_reg[0]);
						txSt_reg <= usc_pkg::USC_PAR;
					end else begin
						txd_reg <= 1'b1;
						txSt_reg <= usc_pkg::USC_STOP1;
					end
				end
				usc_pkg::USC_PAR: begin
					txd_reg <= 1'b1;
					txSt_reg <= usc_pkg::USC_STOP1;
				end
				usc_pkg::USC_STOP1: begin
					txd_reg <= 1'b1;
					txSt_reg <= stop2_reg ? usc_pkg::USC_STOP2
						: usc_pkg::USC_IDLE;
				end
			endcase
			end
		end
	end
	assign link.devTxd = txd_reg;

	// Receiver
	usc_pkg::usc_state_e rxSt_reg;
	logic [8:0] rxSh_reg;
	logic [3:0] rxPh_reg, rxBit_reg;
	logic rxHeld_reg, rxFe_reg;
	logic [10:0] fifo_reg [usc_pkg::FIFO_DEPTH]; // {dor, fe, 9 data}
	logic wp_reg, rp_reg;
	logic [1:0] cnt2_reg;
	wire fifoFull = cnt2_reg == 2'(usc_pkg::FIFO_DEPTH);
	wire [3:0] mid = dbl_reg ? usc_pkg::MID_DOUBLE : usc_pkg::MID_NORMAL;
	// Async samples at the middle phase of each bit; sync at sample edge
	wire rxSmp = syncMode_reg ? smpEdge
		: (baudTick && rxPh_reg == mid);
	wire rxStart = syncMode_reg ? (smpEdge && !link.peerTxd)
		: (baudTick && !link.peerTxd);
	wire pop = rdData && cnt2_reg != 2'h0;
	wire push = rxHeld_reg && !fifoFull;
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rxSt_reg <= usc_pkg::USC_IDLE;
			rxSh_reg <= 9'h000;
			rxPh_reg <= 4'h0;
			rxBit_reg <= 4'h0;
			rxHeld_reg <= 1'b0;
			rxFe_reg <= 1'b0;
			wp_reg <= 1'b0;
			rp_reg <= 1'b0;
			cnt2_reg <= 2'h0;
			fifo_reg[0] <= 11'h000;
			fifo_reg[1] <= 11'h000;
		end else begin
			if (!syncMode_reg && baudTick && rxSt_reg != usc_pkg::USC_IDLE) begin
				rxPh_reg <= ({1'b0, rxPh_reg} == ovs - 5'h01) ? 4'h0
					: rxPh_reg + 4'h1;
			end
			if (push) begin
				fifo_reg[wp_reg] <= {1'b0, rxFe_reg, rxSh_reg};
				wp_reg <= ~wp_reg;
				rxHeld_reg <= 1'b0;
			end
			if (pop) begin
				rp_reg <= ~rp_reg;
			end
			cnt2_reg <= cnt2_reg + 2'(push) - 2'(pop);
			unique case (rxSt_reg)
			usc_pkg::USC_IDLE: begin
				if (rxStart) begin
					rxPh_reg <= 4'h1;
					// Held character lost: mark overrun on newest entry
					if (rxHeld_reg && !push) begin
						fifo_reg[~wp_reg][10] <= 1'b1;
						rxHeld_reg <= 1'b0;
					end
					rxSt_reg <= syncMode_reg ? usc_pkg::USC_DATA
						: usc_pkg::USC_START;
					rxBit_reg <= 4'h0;
					rxSh_reg <= 9'h000;
				end
			end
			usc_pkg::USC_START: begin
				if (rxSmp) begin
					rxSt_reg <= link.peerTxd ? usc_pkg::USC_IDLE
						: usc_pkg::USC_DATA;
				end
			end
			usc_pkg::USC_DATA: begin
				if (rxSmp) begin
					rxSh_reg[rxBit_reg] <= link.peerTxd;
					rxBit_reg <= rxBit_reg + 4'h1;
					if (rxBit_reg + 4'h1 == nBits) begin
						rxSt_reg <= par_reg[1] ? usc_pkg::USC_PAR
							: usc_pkg::USC_STOP1;
					end
				end
			end
			usc_pkg::USC_PAR: begin
				if (rxSmp) begin
					rxSt_reg <= usc_pkg::USC_STOP1;
				end
			end
			usc_pkg::USC_STOP1, usc_pkg::USC_STOP2: begin
				if (rxSmp) begin
					rxFe_reg <= !link.peerTxd;
					rxHeld_reg <= 1'b1;
					rxSt_reg <= usc_pkg::USC_IDLE;
				end
			end
			endcase
		end
	end
	wire [10:0] head = fifo_reg[rp_reg];

	// Register file
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			div_reg <= usc_pkg::DIV_RESET;
			{syncMode_reg, clkDir_reg, dbl_reg, pol_reg} <= 4'h0;
			stop2_reg <= 1'b0;
			size_reg <= usc_pkg::SIZE_5;
			par_reg <= usc_pkg::PAR_NONE;
			txNinth_reg <= 1'b0;
			regRdata_reg <= 8'h00;
		end else begin
			if (wrDivL) begin
				div_reg[7:0] <= regWdata;
			end
			if (wrDivH) begin
				div_reg[11:8] <= regWdata[3:0];
			end
			if (wrCtrl) begin
				{syncMode_reg, clkDir_reg, dbl_reg, pol_reg} <= regWdata[7:4];
				stop2_reg <= regWdata[3];
				size_reg <= regWdata[2:0];
			end
			if (regWr && regAddr == usc_pkg::ADDR_STAT) begin
				par_reg <= regWdata[1:0];
				txNinth_reg <= regWdata[2];
			end
			unique case (regAddr)
			usc_pkg::ADDR_DATA: regRdata_reg <= head[7:0];
			usc_pkg::ADDR_STAT: regRdata_reg <= {cnt2_reg != 2'h0, !txFull_reg,
				head[10:9], head[8], txNinth_reg, par_reg};
			usc_pkg::ADDR_DIVL: regRdata_reg <= div_reg[7:0];
			usc_pkg::ADDR_DIVH: regRdata_reg <= {4'h0, div_reg[11:8]};
			usc_pkg::ADDR_CTRL: regRdata_reg <= {syncMode_reg, clkDir_reg,
				dbl_reg, pol_reg, stop2_reg, size_reg};
			default: regRdata_reg <= 8'h00;
			endcase
		end
	end
	assign regRdata = regRdata_reg;
endmodule : usc_dev
`default_nettype wire

// >>> hdl/usc_peer.sv
// Far end: synchronous serial peer. Drives the transfer clock when the
// device is a slave, else follows the device clock. Fixed 8N1 format.
`timescale 1ns/100ps
`default_nettype none
module usc_peer (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic driveClk,
	input wire logic pol,
	input wire logic [7:0] txByte,
	input wire logic txGo,
	output logic txBusy,
	output logic [7:0] rxByte,
	output logic rxValid,
	usc_link_if.peer link
);
	// Own clock at mclk/8, below a quarter of mclk
	logic [1:0] div_reg;
	logic ck_reg, prev_reg, txd_reg, busy_reg, rxOn_reg, rxValid_reg;
	logic [9:0] sh_reg;
	logic [3:0] n_reg, rn_reg;
	logic [8:0] rs_reg;
	logic [7:0] rxByte_reg;
	wire ck = driveClk ? ck_reg : link.clkPin;
	wire rise = ck && !prev_reg;
	wire fall = !ck && prev_reg;
	wire chg = pol ? fall : rise;
	wire smp = pol ? rise : fall;
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			div_reg <= 2'h0;
			ck_reg <= 1'b0;
			prev_reg <= 1'b0;
			txd_reg <= 1'b1;
			busy_reg <= 1'b0;
			sh_reg <= 10'h3FF;
			n_reg <= 4'h0;
			rxOn_reg <= 1'b0;
			rn_reg <= 4'h0;
			rs_reg <= 9'h000;
			rxByte_reg <= 8'h00;
			rxValid_reg <= 1'b0;
		end else begin
			div_reg <= div_reg + 2'h1;
			if (div_reg == 2'h3) begin
				ck_reg <= ~ck_reg;
			end
			prev_reg <= ck;
			rxValid_reg <= 1'b0;
			if (txGo && !busy_reg) begin
				sh_reg <= {1'b1, txByte, 1'b0};
				n_reg <= 4'hA;
				busy_reg <= 1'b1;
			end else if (chg && busy_reg) begin
				txd_reg <= sh_reg[0];
				sh_reg <= {1'b1, sh_reg[9:1]};
				n_reg <= n_reg - 4'h1;
				busy_reg <= n_reg != 4'h1;
			end
			if (smp) begin
				if (!rxOn_reg && !link.devTxd) begin
					rxOn_reg <= 1'b1;
					rn_reg <= 4'h0;
				end else if (rxOn_reg) begin
					rs_reg <= {link.devTxd, rs_reg[8:1]};
					rn_reg <= rn_reg + 4'h1;
					if (rn_reg == 4'h8) begin
						rxOn_reg <= 1'b0;
						rxByte_reg <= rs_reg[8:1];
						rxValid_reg <= link.devTxd;
					end
				end
			end
		end
	end
	assign link.peerTxd = txd_reg;
	assign link.peerClkOut = ck_reg;
	assign link.peerClkOe = driveClk;
	assign txBusy = busy_reg;
	assign rxByte = rxByte_reg;
	assign rxValid = rxValid_reg;
endmodule : usc_peer
`default_nettype wire

// >>> dv/usc_link_assertions.sv
// Checker for the serial link between the device end and the peer end.
// Assumes sync master runs at divisor 3 and the peer clocks at mclk/8.
`timescale 1ns/100ps
`default_nettype none
module usc_link_assertions (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic devTxd,
	input wire logic peerTxd,
	input wire logic devClkOut,
	input wire logic devClkOe,
	input wire logic peerClkOut,
	input wire logic peerClkOe,
	input wire logic clkPin
);
	// Sync 8N1 frame: start plus eight zeros of eight cycles at most
	localparam int LOW_MAX = 80;
	logic [7:0] devLow_reg;
	logic [7:0] peerLow_reg;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!arst_n);
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			devLow_reg <= 8'h00;
			peerLow_reg <= 8'h00;
		end else begin
			devLow_reg <= (devTxd || !devClkOe) ? 8'h00 : devLow_reg + 8'h01;
			peerLow_reg <= peerTxd ? 8'h00 : peerLow_reg + 8'h01;
		end
	end
	a_one_clk_driver:
		assert property (!(devClkOe && peerClkOe))
		else $error("both ends drive the transfer clock");
	a_peer_clk_hold:
		assert property (peerClkOe && $past(peerClkOe) && $changed(peerClkOut)
			|=> (!peerClkOe || $stable(peerClkOut)) [*3])
		else $error("peer clock half period below four cycles");
	a_master_half:
		assert property (devClkOe && $past(devClkOe) && $changed(devClkOut)
			|=> (!devClkOe || $stable(devClkOut)) [*3])
		else $error("master clock half period not divisor plus one");
	a_slave_txd_lag:
		assert property (peerClkOe && $changed(devTxd) |->
			($past(clkPin) != $past(clkPin, 2)) ||
			($past(clkPin, 2) != $past(clkPin, 3)) ||
			($past(clkPin, 3) != $past(clkPin, 4)))
		else $error("slave data change not tied to a clock edge");
	a_master_txd_edge:
		assert property (devClkOe && $changed(devTxd) |->
			$changed(devClkOut) || ($past(devClkOut) != $past(devClkOut, 2)))
		else $error("master data change off the change edge");
	a_dev_sync_low:
		assert property (devLow_reg < LOW_MAX)
		else $error("device line low beyond one sync frame");
	a_peer_low:
		assert property (peerLow_reg < LOW_MAX)
		else $error("peer line low beyond one frame");
	a_async_bit_min:
		assert property (!devClkOe && !peerClkOe && $changed(devTxd)
			|=> $stable(devTxd) [*7])
		else $error("async bit shorter than eight cycles");
endmodule : usc_link_assertions
`default_nettype wire

// >>> dv/usc_clockgen_frame_format_tb.sv
// Testbench: device and peer joined over the link interface.
// Assumes one 25 MHz clock; the bench resolves the clock pin.
`timescale 1ns/100ps
`default_nettype none
module usc_clockgen_frame_format_tb;
	logic mclk = 1'b0;
	logic arst_n = 1'b0;
	logic [3:0] regAddr = 4'h0;
	logic [7:0] regWdata = 8'h00;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	logic [7:0] regRdata;
	logic driveClk = 1'b0;
	logic pol = 1'b0;
	logic [7:0] txByte = 8'h00;
	logic txGo = 1'b0;
	logic txBusy;
	logic [7:0] rxByte;
	logic rxValid;
	int fails = 0;
	int checks_done = 0;
	usc_link_if link ();
	assign link.clkPin = link.devClkOe ? link.devClkOut :
		(link.peerClkOe ? link.peerClkOut : 1'b1);
	usc_dev i_usc_dev (.mclk(mclk), .arst_n(arst_n), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd),
		.regRdata(regRdata), .link(link));
	usc_peer i_usc_peer (.mclk(mclk), .arst_n(arst_n), .driveClk(driveClk),
		.pol(pol), .txByte(txByte), .txGo(txGo), .txBusy(txBusy),
		.rxByte(rxByte), .rxValid(rxValid), .link(link));
	usc_link_assertions i_usc_link_assertions (.mclk(mclk), .arst_n(arst_n),
		.devTxd(link.devTxd), .peerTxd(link.peerTxd),
		.devClkOut(link.devClkOut), .devClkOe(link.devClkOe),
		.peerClkOut(link.peerClkOut), .peerClkOe(link.peerClkOe),
		.clkPin(link.clkPin));
	always #20 mclk = ~mclk;
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time,
				seen, exp);
		end
	endtask : chk
	task automatic report_and_stop();
		if (fails == 0 && checks_done > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : report_and_stop
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge mclk);
		regWr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge mclk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge mclk);
		regRd <= 1'b0;
		#1 d = regRdata;
	endtask : rd
	// Samples one async frame at mid-bit; bitc is cycles per bit
	task automatic see_frame(input int bitc, input int nb,
		input logic [1:0] par, input logic st2, input logic [8:0] d);
		int n;
		n = 0;
		while (link.devTxd !== 1'b0 && n < 20000) begin
			@(posedge mclk);
			n++;
		end
		chk(16'(n < 20000), 16'h0001);
		repeat (bitc / 2) @(posedge mclk);
		chk(16'(link.devTxd), 16'h0000);
		for (int i = 0; i < nb; i++) begin
			repeat (bitc) @(posedge mclk);
			chk(16'(link.devTxd), 16'(d[i]));
		end
		if (par != usc_pkg::PAR_NONE) begin
			repeat (bitc) @(posedge mclk);
			chk(16'(link.devTxd), 16'(^(d & 9'((1 << nb) - 1)) ^ par[0]));
		end
		repeat (st2 ? 2 : 1) begin
			repeat (bitc) @(posedge mclk);
			chk(16'(link.devTxd), 16'h0001);
		end
		repeat (bitc) @(posedge mclk);
	endtask : see_frame
	task automatic t_formats();
		logic [2:0] sz;
		logic [1:0] par;
		logic [8:0] d;
		for (int si = 0; si < 5; si++) begin
			for (int pi = 0; pi < 6; pi++) begin
				sz = (si == 4) ? usc_pkg::SIZE_9 : 3'(si);
				par = (pi < 2) ? usc_pkg::PAR_NONE : 2'(pi / 2 + 1);
				d = 9'h1A5 ^ 9'(si * 37 + pi * 11);
				wr(usc_pkg::ADDR_CTRL, {4'h0, 1'(pi % 2), sz});
				wr(usc_pkg::ADDR_STAT, {5'h00, d[8], par});
				wr(usc_pkg::ADDR_DATA, d[7:0]);
				see_frame(16, (si == 4) ? 9 : si + 5, par, 1'(pi % 2), d);
			end
		end
	endtask : t_formats
	task automatic t_divisor();
		wr(usc_pkg::ADDR_DIVH, 8'h01);
		wr(usc_pkg::ADDR_DIVL, 8'h00);
		wr(usc_pkg::ADDR_CTRL, 8'h00);
		wr(usc_pkg::ADDR_STAT, 8'h00);
		wr(usc_pkg::ADDR_DATA, 8'h15);
		see_frame(16 * 257, 5, usc_pkg::PAR_NONE, 1'b0, 9'h015);
		wr(usc_pkg::ADDR_CTRL, 8'h20);
		wr(usc_pkg::ADDR_DATA, 8'h0A);
		see_frame(8 * 257, 5, usc_pkg::PAR_NONE, 1'b0, 9'h00A);
	endtask : t_divisor
	task automatic peer_send(input logic [7:0] b);
		int n;
		@(posedge mclk);
		txByte <= b;
		txGo <= 1'b1;
		@(posedge mclk);
		txGo <= 1'b0;
		repeat (4) @(posedge mclk);
		n = 0;
		while (txBusy !== 1'b0 && n < 3000) begin
			@(posedge mclk);
			n++;
		end
		chk(16'(n < 3000), 16'h0001);
		repeat (16) @(posedge mclk);
	endtask : peer_send
	task automatic t_xchg(input logic [7:0] ctrl, input logic drv,
		input logic p, input logic [7:0] a, input logic [7:0] b);
		logic [7:0] s;
		int n;
		// Release the peer clock first so the two ends never drive together
		@(posedge mclk);
		driveClk <= 1'b0;
		wr(usc_pkg::ADDR_CTRL, ctrl);
		@(posedge mclk);
		driveClk <= drv;
		pol <= p;
		repeat (16) @(posedge mclk);
		wr(usc_pkg::ADDR_DATA, a);
		n = 0;
		while (rxValid !== 1'b1 && n < 3000) begin
			@(posedge mclk);
			n++;
		end
		chk(16'(n < 3000), 16'h0001);
		chk(16'(rxByte), 16'(a));
		peer_send(b);
		rd(usc_pkg::ADDR_STAT, s);
		chk(16'(s[7]), 16'h0001);
		rd(usc_pkg::ADDR_DATA, s);
		chk(16'(s), 16'(b));
	endtask : t_xchg
	// Fourth start displaces the held third character
	task automatic t_fifo();
		logic [7:0] s;
		logic [1:0] ex [3] = '{2'b10, 2'b11, 2'b10};
		for (int i = 0; i < 4; i++) begin
			peer_send(8'h50 + 8'(i));
		end
		for (int k = 0; k < 3; k++) begin
			rd(usc_pkg::ADDR_STAT, s);
			chk(16'({s[7], s[5]}), 16'(ex[k]));
			rd(usc_pkg::ADDR_DATA, s);
			chk(16'(s), 16'((k < 2) ? 8'h50 + 8'(k) : 8'h53));
		end
		rd(usc_pkg::ADDR_STAT, s);
		chk(16'(s[7]), 16'h0000);
	endtask : t_fifo
	// Seven-bit receive of an 8N1 frame: bit 7 falls in the stop slot
	task automatic t_frame_err();
		logic [7:0] s;
		wr(usc_pkg::ADDR_CTRL, 8'h92);
		for (int k = 0; k < 2; k++) begin
			peer_send((k == 0) ? 8'h35 : 8'hB5);
			rd(usc_pkg::ADDR_STAT, s);
			chk(16'({s[7], s[4]}), (k == 0) ? 16'h0003 : 16'h0002);
			rd(usc_pkg::ADDR_DATA, s);
			chk(16'(s), 16'h0035);
		end
	endtask : t_frame_err
	task automatic t_reset();
		logic [7:0] s;
		rd(usc_pkg::ADDR_CTRL, s);
		chk(16'(s), 16'h0000);
		rd(4'hF, s);
		chk(16'(s), 16'h0000);
		chk(16'(link.devTxd), 16'h0001);
		chk(16'(link.devClkOe), 16'h0000);
	endtask : t_reset
	initial begin
		repeat (16) @(posedge mclk);
		arst_n <= 1'b1;
		t_reset();
		t_formats();
		t_divisor();
		wr(usc_pkg::ADDR_DIVH, 8'h00);
		wr(usc_pkg::ADDR_DIVL, 8'h03);
		t_xchg(8'hC3, 1'b0, 1'b0, 8'hA5, 8'h3C);
		t_xchg(8'h83, 1'b1, 1'b0, 8'h5A, 8'hC3);
		t_xchg(8'h93, 1'b1, 1'b1, 8'h96, 8'h69);
		t_fifo();
		t_frame_err();
		t_xchg(8'hD3, 1'b0, 1'b1, 8'hC6, 8'h39);
		report_and_stop();
	end
	// Run needs about 58k cycles; give up at 90k
	initial begin
		#3600000;
		fails++;
		report_and_stop();
	end
endmodule : usc_clockgen_frame_format_tb
`default_nettype wire
